// ===== include/thcp_pkg.sv
// Package with register map, field layout, reset values and timing constants.
package thcp_pkg;

   // Register byte offsets on the serial register port.
   localparam logic [7:0] OFS_PUMP_LOCKOUT = 8'h76;
   localparam logic [7:0] OFS_THERM_LIMITS = 8'h77;
   localparam logic [7:0] OFS_DERATE_CFG   = 8'h78;

   // Register values after reset.
   localparam logic [7:0] RST_PUMP_LOCKOUT = 8'hDC;
   localparam logic [7:0] RST_THERM_LIMITS = 8'hFF;
   localparam logic [7:0] RST_DERATE_CFG   = 8'h3E;

   // Writable bits of the pump and lockout register; bits 6:4 are reserved.
   localparam logic [7:0] PUMP_LOCKOUT_MASK = 8'h8F;

   // Field positions.
   localparam int LOCKOUT_BIT      = 7;
   localparam int PUMP_RATE_LSB    = 2;
   localparam int PUMP_EN_BIT      = 1;
   localparam int EXT_CLK_EN_BIT   = 0;
   localparam int UPPER_LIM_LSB    = 4;
   localparam int LOWER_LIM_LSB    = 0;
   localparam int DIE_THR_LSB      = 6;
   localparam int STEP_CODE_LSB    = 1;
   localparam int COMP_EN_BIT      = 0;

   // Clock and timing figures.
   localparam int CLK_HZ           = 100_000_000;
   localparam int EXT_CLK_HZ       = 100_000;
   localparam int PUMP_BASE_HZ     = 104_167;
   localparam int STEP_UNIT_S      = 2;
   // Half periods in cycles; each higher pump rate halves the half period.
   localparam logic [9:0] EXT_CLK_HALF  = 10'(CLK_HZ / (2 * EXT_CLK_HZ));
   // Rounded to nearest, since plain division would truncate 479.99 down to 479.
   localparam logic [9:0] PUMP_HALF_MAX = 10'((CLK_HZ + PUMP_BASE_HZ) / (2 * PUMP_BASE_HZ));
   localparam int SEC_CYCLES       = CLK_HZ;

   // Thermistor limit table in units of 10 ohm, code 0 first.
   localparam logic [12:0] THERM_OHM10 [16] = '{
      13'd7967, 13'd4335, 13'd2977, 13'd2267, 13'd1830, 13'd1534, 13'd1321, 13'd1160,
      13'd1034, 13'd932,  13'd849,  13'd779,  13'd720,  13'd669,  13'd625,  13'd587};

   // Die temperature threshold in degrees C, zero meaning de-rating off.
   localparam logic [6:0] DIE_THR_C [4] = '{7'd0, 7'd90, 7'd100, 7'd110};

   // Lockout level in units of 100 mV.
   localparam logic [4:0] LOCKOUT_LOW_DV  = 5'd25;
   localparam logic [4:0] LOCKOUT_HIGH_DV = 5'd30;

   // Soft start sequencing states, Gray coded along idle, start, run.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_RUN   = 2'b11
   } thcp_state_t;

   // Register port request bundle.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } thcp_req_t;

endpackage

// ===== logic/thcp_clkdiv.sv
// Square wave divider with run control and programmable half period.
module thcp_clkdiv (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [9:0] half_cnt,
   output logic            wave_o
);

   logic [9:0] cnt_q;

   // Counter toggles the wave every half period; stopping parks it low.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q  <= 10'h000;
         wave_o <= 1'b0;
      end else if (!run) begin
         cnt_q  <= 10'h000;
         wave_o <= 1'b0;
      end else if (cnt_q >= half_cnt - 10'd1) begin
         // Using >= keeps a shortened half period from running past the limit.
         cnt_q  <= 10'h000;
         wave_o <= ~wave_o;
      end else begin
         cnt_q  <= cnt_q + 10'd1;
      end
   end

endmodule

// ===== logic/thcp_cfg_bank.sv
// Thermal, charge pump and lockout configuration bank with its control outputs.
module thcp_cfg_bank #(
   parameter int SEC_CYCLES = thcp_pkg::SEC_CYCLES
) (
   input  wire logic               MCLK,
   input  wire logic               RESET,
   input  wire thcp_pkg::thcp_req_t REG_REQ,
   output logic [7:0]              REG_RDATA,
   output logic                    REG_RVALID,
   input  wire logic               SOFT_START,
   output logic                    LOCKOUT_HIGH_SEL,
   output logic [4:0]              LOCKOUT_LEVEL_DV,
   output logic                    PUMP_ENABLE,
   output logic                    PUMP_CLOCK,
   output logic                    SQUARE_WAVE_OUT,
   output logic [12:0]             UPPER_LIMIT_OHM10,
   output logic [12:0]             LOWER_LIMIT_OHM10,
   output logic                    DIE_DERATE_ENABLE,
   output logic [6:0]              DIE_DERATE_C,
   output logic [6:0]              STEP_INTERVAL_S,
   output logic                    COMP_ENABLE,
   output logic                    STEP_TICK
);
   import thcp_pkg::*;

   localparam int SEC_W = $clog2(SEC_CYCLES + 1);

   logic [7:0]  pump_lockout_q;
   logic [7:0]  therm_limits_q;
   logic [7:0]  derate_cfg_q;
   logic [7:0]  rdata_d;
   thcp_state_t state_q;
   logic        active;
   logic [1:0]  rate_code;
   logic [9:0]  pump_half;
   logic        pump_wave;
   logic        ext_wave;
   logic [SEC_W-1:0] sec_cnt_q;
   logic [6:0]  step_sec_q;
   logic [6:0]  step_len;

   // Register writes; reserved bits of the pump register are never stored.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         pump_lockout_q <= RST_PUMP_LOCKOUT & PUMP_LOCKOUT_MASK;
         therm_limits_q <= RST_THERM_LIMITS;
         derate_cfg_q   <= RST_DERATE_CFG;
      end else if (REG_REQ.wr) begin
         case (REG_REQ.addr)
            OFS_PUMP_LOCKOUT: begin
               pump_lockout_q <= REG_REQ.wdata & PUMP_LOCKOUT_MASK;
            end
            OFS_THERM_LIMITS: begin
               therm_limits_q <= REG_REQ.wdata;
            end
            OFS_DERATE_CFG: begin
               derate_cfg_q <= REG_REQ.wdata;
            end
            default: begin
               // Writes to any other offset are dropped.
            end
         endcase
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      case (REG_REQ.addr)
         OFS_PUMP_LOCKOUT: rdata_d = pump_lockout_q;
         OFS_THERM_LIMITS: rdata_d = therm_limits_q;
         OFS_DERATE_CFG:   rdata_d = derate_cfg_q;
         default:          rdata_d = 8'h00;
      endcase
   end

   // Read data is captured one cycle after the strobe and held until the next read.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_REQ.rd;
         if (REG_REQ.rd) begin
            REG_RDATA <= rdata_d;
         end
      end
   end

   // Soft start sequencing: the pump and external clock may only run once it begins.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (SOFT_START) begin
                  state_q <= ST_START;
               end
            end
            ST_START: begin
               state_q <= SOFT_START ? ST_RUN : ST_IDLE;
            end
            ST_RUN: begin
               if (!SOFT_START) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign active = (state_q == ST_START) || (state_q == ST_RUN);

   // Pump half period halves per rate step: 104, 208, 417, 833 kHz.
   assign rate_code = pump_lockout_q[PUMP_RATE_LSB +: 2];
   assign pump_half = PUMP_HALF_MAX >> rate_code;

   // Pump clock only runs while the pump itself is enabled and started.
   thcp_clkdiv u_pump_div (
      .clk      (MCLK),
      .rst      (RESET),
      .run      (active && pump_lockout_q[PUMP_EN_BIT]),
      .half_cnt (pump_half),
      .wave_o   (pump_wave)
   );

   // External pump clock at a fixed 100 kHz, half duty by equal half periods.
   thcp_clkdiv u_ext_div (
      .clk      (MCLK),
      .rst      (RESET),
      .run      (active && pump_lockout_q[EXT_CLK_EN_BIT]),
      .half_cnt (EXT_CLK_HALF),
      .wave_o   (ext_wave)
   );

   // Pump and clock outputs are re-registered so every pin comes from a flop.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         PUMP_ENABLE     <= 1'b0;
         PUMP_CLOCK      <= 1'b0;
         SQUARE_WAVE_OUT <= 1'b0;
      end else begin
         PUMP_ENABLE     <= active && pump_lockout_q[PUMP_EN_BIT];
         PUMP_CLOCK      <= pump_wave;
         SQUARE_WAVE_OUT <= ext_wave;
      end
   end

   // Lockout level select; the PLL limit on the low level is left to software.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         LOCKOUT_HIGH_SEL <= 1'b0;
         LOCKOUT_LEVEL_DV <= LOCKOUT_LOW_DV;
      end else begin
         LOCKOUT_HIGH_SEL <= pump_lockout_q[LOCKOUT_BIT];
         LOCKOUT_LEVEL_DV <= pump_lockout_q[LOCKOUT_BIT] ? LOCKOUT_HIGH_DV
                                                         : LOCKOUT_LOW_DV;
      end
   end

   // Thermistor limits decoded to resistance; a lower code means a larger resistance.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         UPPER_LIMIT_OHM10 <= 13'h0000;
         LOWER_LIMIT_OHM10 <= 13'h0000;
      end else begin
         UPPER_LIMIT_OHM10 <= THERM_OHM10[therm_limits_q[UPPER_LIM_LSB +: 4]];
         LOWER_LIMIT_OHM10 <= THERM_OHM10[therm_limits_q[LOWER_LIM_LSB +: 4]];
      end
   end

   // Die de-rating threshold and compensation enable.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         DIE_DERATE_ENABLE <= 1'b0;
         DIE_DERATE_C      <= 7'h00;
         COMP_ENABLE       <= 1'b0;
      end else begin
         DIE_DERATE_ENABLE <= (derate_cfg_q[DIE_THR_LSB +: 2] != 2'b00);
         DIE_DERATE_C      <= DIE_THR_C[derate_cfg_q[DIE_THR_LSB +: 2]];
         COMP_ENABLE       <= derate_cfg_q[COMP_EN_BIT];
      end
   end

   // Step interval in seconds is two times code plus two.
   assign step_len = 7'(STEP_UNIT_S) * (7'(derate_cfg_q[STEP_CODE_LSB +: 5]) + 7'd1);

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         STEP_INTERVAL_S <= 7'h00;
      end else begin
         STEP_INTERVAL_S <= step_len;
      end
   end

   // Step timer runs only with compensation on, so a disabled sensor emits no steps.
   // Shortening the interval below the elapsed count fires the step at the next second boundary.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         sec_cnt_q  <= '0;
         step_sec_q <= 7'h00;
         STEP_TICK  <= 1'b0;
      end else if (!derate_cfg_q[COMP_EN_BIT]) begin
         sec_cnt_q  <= '0;
         step_sec_q <= 7'h00;
         STEP_TICK  <= 1'b0;
      end else if (sec_cnt_q == SEC_W'(SEC_CYCLES - 1)) begin
         sec_cnt_q <= '0;
         if (step_sec_q + 7'd1 >= step_len) begin
            step_sec_q <= 7'h00;
            STEP_TICK  <= 1'b1;
         end else begin
            step_sec_q <= step_sec_q + 7'd1;
            STEP_TICK  <= 1'b0;
         end
      end else begin
         sec_cnt_q <= sec_cnt_q + SEC_W'(1);
         STEP_TICK <= 1'b0;
      end
   end

endmodule

// ===== testbench/thcp_cfg_monitor.sv
// Port checker for the configuration bank.
module thcp_cfg_monitor #(
   parameter int SEC_CYCLES = 10
) (
   input wire logic                 MCLK,
   input wire logic                 RESET,
   input wire thcp_pkg::thcp_req_t  REG_REQ,
   input wire logic                 REG_RVALID,
   input wire logic                 SOFT_START,
   input wire logic                 LOCKOUT_HIGH_SEL,
   input wire logic [4:0]           LOCKOUT_LEVEL_DV,
   input wire logic                 PUMP_ENABLE,
   input wire logic                 PUMP_CLOCK,
   input wire logic                 SQUARE_WAVE_OUT,
   input wire logic                 DIE_DERATE_ENABLE,
   input wire logic [6:0]           DIE_DERATE_C,
   input wire logic [6:0]           STEP_INTERVAL_S,
   input wire logic                 COMP_ENABLE,
   input wire logic                 STEP_TICK
);
   timeunit 1ns;
   timeprecision 1ps;
   import thcp_pkg::*;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   // Read answer and the quiet state after soft start ends.
   sequence s_rd_answer;
      ##1 REG_RVALID;
   endsequence
   sequence s_quiet;
      !PUMP_ENABLE && !SQUARE_WAVE_OUT;
   endsequence
   // The wave check is paused once soft start drops, since the wave parks early then.
   property p_sqw_hold;
      @(posedge MCLK) disable iff (RESET || !SOFT_START)
         $rose(SQUARE_WAVE_OUT) |-> SQUARE_WAVE_OUT [*8];
   endproperty
   a_read_answer: assert property (REG_REQ.rd |-> s_rd_answer) else $error("read not answered");
   a_rvalid_cause: assert property (REG_RVALID |-> $past(REG_REQ.rd)) else $error("stray rvalid");
   a_lockout_level: assert property (LOCKOUT_LEVEL_DV == (LOCKOUT_HIGH_SEL ? 5'd30 : 5'd25))
      else $error("lockout level wrong");
   a_soft_stop: assert property ($fell(SOFT_START) |-> ##3 s_quiet)
      else $error("outputs stay on after soft start");
   a_pump_parked: assert property (!PUMP_ENABLE [*4] |-> !PUMP_CLOCK)
      else $error("pump clock runs while off");
   a_sqw_half_hold: assert property (p_sqw_hold) else $error("square wave half too short");
   a_die_enable: assert property (DIE_DERATE_ENABLE == (DIE_DERATE_C != 7'd0))
      else $error("de-rate enable mismatch");
   a_step_range: assert property (!$past(RESET) |-> !STEP_INTERVAL_S[0] &&
      STEP_INTERVAL_S inside {[2:64]}) else $error("step interval out of range");
   a_tick_comp: assert property (STEP_TICK |-> COMP_ENABLE || $past(COMP_ENABLE))
      else $error("tick without compensation");
endmodule

bind thcp_cfg_bank thcp_cfg_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_thcp_cfg_monitor (
   .MCLK(MCLK), .RESET(RESET), .REG_REQ(REG_REQ), .REG_RVALID(REG_RVALID),
   .SOFT_START(SOFT_START), .LOCKOUT_HIGH_SEL(LOCKOUT_HIGH_SEL),
   .LOCKOUT_LEVEL_DV(LOCKOUT_LEVEL_DV), .PUMP_ENABLE(PUMP_ENABLE), .PUMP_CLOCK(PUMP_CLOCK),
   .SQUARE_WAVE_OUT(SQUARE_WAVE_OUT), .DIE_DERATE_ENABLE(DIE_DERATE_ENABLE),
   .DIE_DERATE_C(DIE_DERATE_C), .STEP_INTERVAL_S(STEP_INTERVAL_S),
   .COMP_ENABLE(COMP_ENABLE), .STEP_TICK(STEP_TICK));

// ===== testbench/thcp_cfg_bank_test.sv
// Self-checking bench for the configuration bank.
module thcp_cfg_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   import thcp_pkg::*;
   logic        MCLK = 1'b0;
   logic        RESET = 1'b1;
   logic        SOFT_START = 1'b0;
   thcp_req_t   req = '0;
   logic [7:0]  rdata;
   logic        rvalid, lock_hi, pump_en, pump_clk, square_wave_out_pin, die_en, comp_en, tick;
   logic [4:0]  lock_dv;
   logic [12:0] upper, lower;
   logic [6:0]  die_c, step_s;
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          ohm10 [16] = '{7967, 4335, 2977, 2267, 1830, 1534, 1321, 1160,
                               1034, 932, 849, 779, 720, 669, 625, 587};
   int          die_tbl [4] = '{0, 90, 100, 110};

   // A short second keeps step intervals within a few hundred cycles.
   thcp_cfg_bank #(.SEC_CYCLES(10)) u_thcp_cfg_bank (
      .MCLK(MCLK), .RESET(RESET), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .SOFT_START(SOFT_START), .LOCKOUT_HIGH_SEL(lock_hi), .LOCKOUT_LEVEL_DV(lock_dv),
      .PUMP_ENABLE(pump_en), .PUMP_CLOCK(pump_clk), .SQUARE_WAVE_OUT(square_wave_out_pin),
      .UPPER_LIMIT_OHM10(upper), .LOWER_LIMIT_OHM10(lower), .DIE_DERATE_ENABLE(die_en),
      .DIE_DERATE_C(die_c), .STEP_INTERVAL_S(step_s), .COMP_ENABLE(comp_en),
      .STEP_TICK(tick));

   // Clock and the hang guard.
   always #5 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Writes wait two extra edges so the decoded outputs have landed.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge MCLK);
      req <= '0;
      repeat (2) @(posedge MCLK);
      @(negedge MCLK);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge MCLK);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge MCLK);
      req <= '0;
      @(negedge MCLK);
      chk(rvalid, 1'b1);
      chk(rdata, exp);
   endtask

   function automatic logic wv(input bit p);
      return p ? pump_clk : square_wave_out_pin;
   endfunction

   // The first pass only finds a toggle, the second counts one half period.
   task automatic half_per(input bit p, input int exp);
      int  n;
      logic v;
      repeat (2) begin
         n = 0;
         v = wv(p);
         while (wv(p) === v && n < 2000) begin
            @(negedge MCLK);
            n++;
         end
      end
      chk(n, exp);
   endtask

   task automatic tick_gap(input int exp);
      int n;
      repeat (2) begin
         n = 0;
         @(negedge MCLK);
         while (tick !== 1'b1 && n < 3000) begin
            @(negedge MCLK);
            n++;
         end
      end
      chk(n + 1, exp);
   endtask

   task automatic t_reset();
      rd(OFS_PUMP_LOCKOUT, RST_PUMP_LOCKOUT & PUMP_LOCKOUT_MASK);
      rd(OFS_THERM_LIMITS, RST_THERM_LIMITS);
      rd(OFS_DERATE_CFG, RST_DERATE_CFG);
      rd(8'h79, 8'h00);
      chk(lock_dv, 30);
      chk(upper, 587);
      chk(lower, 587);
      chk(step_s, 64);
      chk(comp_en, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_pump();
      wr(OFS_PUMP_LOCKOUT, 8'h7C);
      rd(OFS_PUMP_LOCKOUT, 8'h0C);
      chk(lock_dv, 25);
      @(posedge MCLK);
      SOFT_START <= 1'b1;
      repeat (600) @(negedge MCLK);
      chk({pump_en, pump_clk, square_wave_out_pin}, 3'b000);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_PUMP_LOCKOUT, 8'h83 | 8'(c << 2));
         chk(pump_en, 1'b1);
         half_per(1'b1, 480 >> c);
      end
      chk(lock_dv, 30);
      half_per(1'b0, 500);
      @(posedge MCLK);
      SOFT_START <= 1'b0;
      repeat (4) @(negedge MCLK);
      chk({pump_en, pump_clk, square_wave_out_pin}, 3'b000);
      $display("test pump done");
   endtask

   task automatic t_limits();
      for (int c = 0; c < 16; c++) begin
         wr(OFS_THERM_LIMITS, {4'(c), 4'(15 - c)});
         chk(upper, ohm10[c]);
         chk(lower, ohm10[15 - c]);
      end
      $display("test limits done");
   endtask

   task automatic t_derate();
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_DERATE_CFG, 8'(c << 6) | 8'h01);
         chk(die_c, die_tbl[c]);
         chk(die_en, c != 0);
      end
      chk(step_s, 2);
      tick_gap(20);
      wr(OFS_DERATE_CFG, 8'h3F);
      tick_gap(640);
      wr(OFS_DERATE_CFG, 8'h3E);
      n = 0;
      repeat (100) begin
         @(negedge MCLK);
         n += int'(tick === 1'b1);
      end
      chk(n, 0);
      $display("test derate done");
   endtask

   task automatic close_out();
      $display("Counts: tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence after the reset hold.
   initial begin
      repeat (8) @(posedge MCLK);
      RESET <= 1'b0;
      t_reset();
      t_pump();
      t_limits();
      t_derate();
      close_out();
   end
endmodule
